// *** dacw_ctrl.sv ***
// Host-side controller that writes 12-bit codes into a multiplying DAC's input latch.
// Assumes user requests come from logic on clock_i; the pins go straight to the DAC.
`timescale 1ns/10ps
`default_nettype none
`include "dacw_regs.svh"

module dacw_ctrl (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [`DACW_CODE_W-1:0] code_i,
    input wire logic split_i,
    input wire logic stream_i,
    output logic [`DACW_CODE_W-1:0] dac_data_o,
    output logic dac_cs_n_o,
    output logic dac_wr_n_o,
    output logic busy_o,
    output logic done_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Timing counts derived from the least pin times.

    // Least times round up to whole cycles and never fall below one cycle.
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + `DACW_CLK_PERIOD_NS - 1) / `DACW_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Select must lead the write strobe and data must lead its end; the longer wins.
    localparam int SETUP_I = (cyc_up(`DACW_T_CS_SETUP_NS) > cyc_up(`DACW_T_DATA_SETUP_NS))
        ? cyc_up(`DACW_T_CS_SETUP_NS) : cyc_up(`DACW_T_DATA_SETUP_NS);
    // Data and select both stay after the write strobe rises.
    localparam int HOLD_I = (cyc_up(`DACW_T_DATA_HOLD_NS) > cyc_up(`DACW_T_CS_HOLD_NS))
        ? cyc_up(`DACW_T_DATA_HOLD_NS) : cyc_up(`DACW_T_CS_HOLD_NS);
    localparam int PULSE_I = cyc_up(`DACW_T_WR_PULSE_NS);
    localparam logic [`DACW_CNT_W-1:0] SETUP_LOAD = `DACW_CNT_W'(SETUP_I - 1);
    localparam logic [`DACW_CNT_W-1:0] PULSE_LOAD = `DACW_CNT_W'(PULSE_I - 1);
    localparam logic [`DACW_CNT_W-1:0] HOLD_LOAD = `DACW_CNT_W'(HOLD_I - 1);

    ////////////////////////////////////////////////////////////////////////////
    // State record.

    // Everything the controller remembers except the phase count kept in u_timer, registered as one word.
    typedef struct packed {
        dacw_pkg::dacw_state_t state; // Current phase.
        logic [`DACW_CODE_W-1:0] code; // Code of the write in progress.
        logic [`DACW_CODE_W-1:0] last; // Code the DAC latch holds after the last write.
        logic [`DACW_CODE_W-1:0] data; // Level on the data pins.
        logic cs_n; // Select pin, low while asserted.
        logic wr_n; // Write pin, low while asserted.
        logic second; // High during the last (or only) access of a write.
        logic busy; // High while a write or streaming is under way.
        logic done; // One-cycle pulse when a write completes.
    } dacw_ctrl_st_t;

    // Reset: strobes released so the DAC holds whatever it has.
    localparam dacw_ctrl_st_t RESET_ST = '{
        state: dacw_pkg::DACW_IDLE,
        code: `DACW_CODE_RESET,
        last: `DACW_CODE_RESET,
        data: `DACW_CODE_RESET,
        cs_n: 1'b1,
        wr_n: 1'b1,
        second: 1'b0,
        busy: 1'b0,
        done: 1'b0
    };

    dacw_ctrl_st_t s_q; // Registered state.
    dacw_ctrl_st_t s_d; // Next state.
    logic tmr_load; // Starts a new phase count.
    logic [`DACW_CNT_W-1:0] tmr_value; // Count for the new phase.
    logic tmr_expired; // Current phase has run its full length.

    // Phase timer shared by setup, strobe and hold.
    dacw_timer u_timer (
        .clk_i(clock_i),
        .rst_i(rst_i),
        .load_i(tmr_load),
        .value_i(tmr_value),
        .expired_o(tmr_expired)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // One process sequences the pins; every branch leaves the strobes defined.
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        tmr_load = 1'b0;
        tmr_value = '0;
        case (s_q.state)
            dacw_pkg::DACW_IDLE: begin
                // Idle: both strobes high, so the DAC ignores the data pins.
                s_d.cs_n = 1'b1;
                s_d.wr_n = 1'b1;
                s_d.busy = 1'b0;
                if (stream_i) begin
                    // Streaming wins over a request; both strobes go low together.
                    s_d.state = dacw_pkg::DACW_STREAM;
                    s_d.cs_n = 1'b0;
                    s_d.wr_n = 1'b0;
                    s_d.data = code_i;
                    s_d.busy = 1'b1;
                end else if (req_i) begin
                    s_d.state = dacw_pkg::DACW_SETUP;
                    s_d.code = code_i;
                    s_d.second = ~split_i;
                    s_d.busy = 1'b1;
                    // Select goes low first, with the data already on the pins.
                    s_d.cs_n = 1'b0;
                    if (split_i) begin
                        // First access carries only the low eight bits.
                        s_d.data = {s_q.last[`DACW_CODE_MSB:`DACW_HIGH_LSB], code_i[`DACW_LOW_MSB:`DACW_CODE_LSB]};
                    end else begin
                        // The whole code goes out as one word, bit 11 on the top pin.
                        s_d.data = code_i;
                    end
                    tmr_load = 1'b1;
                    tmr_value = SETUP_LOAD;
                end
            end
            dacw_pkg::DACW_SETUP: begin
                // Hold select low and data steady until both lead times have passed.
                if (tmr_expired) begin
                    s_d.state = dacw_pkg::DACW_STROBE;
                    s_d.wr_n = 1'b0;
                    tmr_load = 1'b1;
                    tmr_value = PULSE_LOAD;
                end
            end
            dacw_pkg::DACW_STROBE: begin
                // The latch follows the pins while both strobes are low.
                if (tmr_expired) begin
                    s_d.state = dacw_pkg::DACW_HOLD;
                    s_d.wr_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_value = HOLD_LOAD;
                end
            end
            dacw_pkg::DACW_HOLD: begin
                // Data and select stay put after the write strobe rises.
                if (tmr_expired) begin
                    if (!s_q.second) begin
                        // Second access adds the upper four bits; select stays low.
                        s_d.state = dacw_pkg::DACW_SETUP;
                        s_d.second = 1'b1;
                        s_d.data = s_q.code;
                        tmr_load = 1'b1;
                        tmr_value = SETUP_LOAD;
                    end else begin
                        s_d.state = dacw_pkg::DACW_IDLE;
                        s_d.cs_n = 1'b1;
                        s_d.last = s_q.code;
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                    end
                end
            end
            dacw_pkg::DACW_STREAM: begin
                // Transparent mode: pins follow the user code one cycle later.
                if (stream_i) begin
                    s_d.data = code_i;
                end else begin
                    // Both strobes rise with the data still held, freezing the latch.
                    s_d.state = dacw_pkg::DACW_IDLE;
                    s_d.cs_n = 1'b1;
                    s_d.wr_n = 1'b1;
                    s_d.last = s_q.data;
                    s_d.busy = 1'b0;
                end
            end
            default: begin
                // An illegal state falls back to the safe, released state.
                s_d = RESET_ST;
            end
        endcase
    end

    // Register the record; reset releases both strobes.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_q <= RESET_ST;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output is a field of the registered record.
    assign dac_data_o = s_q.data;
    assign dac_cs_n_o = s_q.cs_n;
    assign dac_wr_n_o = s_q.wr_n;
    assign busy_o = s_q.busy;
    assign done_o = s_q.done;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the pin sequence.

    // The write strobe low for exactly the pulse length, then high.
    sequence wr_pulse_s;
        (!dac_wr_n_o) [*5] ##1 dac_wr_n_o;
    endsequence

    // Select low throughout the pulse and the hold that follows.
    sequence cs_through_s;
        (!dac_cs_n_o) [*6];
    endsequence

    a_wr_inside_cs: assert property (
        @(posedge clock_i) disable iff (rst_i) !dac_wr_n_o |-> !dac_cs_n_o)
        else $error("write strobe low without select");

    a_cs_setup_lead: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ($fell(dac_wr_n_o) && s_q.state == dacw_pkg::DACW_STROBE) |-> $past(dac_cs_n_o, 9) == 1'b0)
        else $error("select did not lead write strobe by nine cycles");

    a_wr_pulse_len: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ($fell(dac_wr_n_o) && s_q.state == dacw_pkg::DACW_STROBE) |-> wr_pulse_s and cs_through_s)
        else $error("write pulse length or select hold wrong");

    a_data_steady: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ($rose(dac_wr_n_o) && s_q.state == dacw_pkg::DACW_HOLD) |-> ($stable(dac_data_o) && !dac_cs_n_o))
        else $error("data moved around the write strobe edge");

    a_word_order: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (s_q.state == dacw_pkg::DACW_STROBE && s_q.second) |-> dac_data_o == s_q.code)
        else $error("final access does not carry the full code");

    a_split_low: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (s_q.state == dacw_pkg::DACW_STROBE && !s_q.second)
        |-> dac_data_o[`DACW_LOW_MSB:`DACW_CODE_LSB] == s_q.code[`DACW_LOW_MSB:`DACW_CODE_LSB])
        else $error("first split access lacks the low eight bits");

    a_stream_follow: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (s_q.state == dacw_pkg::DACW_STREAM && $past(stream_i))
        |-> (dac_data_o == $past(code_i) && !dac_cs_n_o && !dac_wr_n_o))
        else $error("streaming pins do not follow the code");

    a_done_release: assert property (
        @(posedge clock_i) disable iff (rst_i)
        done_o |-> (dac_cs_n_o && dac_wr_n_o && $past(dac_cs_n_o) == 1'b0 && dac_data_o == s_q.last))
        else $error("completion without released strobes");

endmodule
`default_nettype wire

// *** dacw_regs.svh ***
// Constants for the DAC write-port controller: pin field layout and strobe timing.
// Assumes a 50 MHz system clock; all times are in nanoseconds.
`ifndef DACW_REGS_SVH
`define DACW_REGS_SVH

// Clock period of clock_i in nanoseconds.
`define DACW_CLK_PERIOD_NS 20

// Width of the conversion code and of the two split-write parts.
`define DACW_CODE_W 12
`define DACW_CODE_MSB 11
`define DACW_CODE_LSB 0
`define DACW_LOW_MSB 7
`define DACW_HIGH_LSB 8

// Least times of the write cycle at the converter's pins.
`define DACW_T_CS_SETUP_NS 180
`define DACW_T_CS_HOLD_NS 0
`define DACW_T_WR_PULSE_NS 100
`define DACW_T_DATA_SETUP_NS 100
`define DACW_T_DATA_HOLD_NS 10

// Width of the phase timer; it must hold the longest phase count.
`define DACW_CNT_W 4

// Reset value of the data pins and of the remembered code.
`define DACW_CODE_RESET 12'h000

`endif

// *** dacw_pkg.sv ***
// Types used by the DAC write-port controller; its phase timer uses none of them.
// Assumes dacw_regs.svh is compiled alongside; this package holds types only.
package dacw_pkg;

    // Phases of one write cycle, plus the transparent streaming mode.
    typedef enum logic [2:0] {
        DACW_IDLE,
        DACW_SETUP,
        DACW_STROBE,
        DACW_HOLD,
        DACW_STREAM
    } dacw_state_t;

endpackage

// *** dacw_timer.sv ***
// Down-counting phase timer used to time the strobe phases of a write.
// Assumes the same clock and synchronous reset as the controller that loads it.
`timescale 1ns/10ps
`default_nettype none
`include "dacw_regs.svh"

module dacw_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [`DACW_CNT_W-1:0] value_i,
    output logic expired_o
);

    // All timer state in one record, filled by one process and held by another.
    typedef struct packed {
        logic [`DACW_CNT_W-1:0] cnt;
    } dacw_timer_st_t;

    dacw_timer_st_t s_q; // Registered state.
    dacw_timer_st_t s_d; // Next state.

    ////////////////////////////////////////////////////////////////////////////
    // A load of N-1 makes the loading phase last exactly N cycles.

    // The count stops at zero so a phase that waits longer stays expired.
    always_comb begin
        s_d = s_q;
        if (load_i) begin
            s_d.cnt = value_i;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - `DACW_CNT_W'(1);
        end
    end

    // Register the record; reset leaves the timer expired.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Expiry is read in the same cycle the count reaches zero.
    assign expired_o = (s_q.cnt == '0);

endmodule
`default_nettype wire

// *** dacw_dac_model.sv ***
// Behavioural model of the converter's 12-bit input latch, as the pins see it.
// Assumes select, write and data come straight from the controller under test.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module dacw_dac_model (
    input wire logic [11:0] data_i,
    input wire logic cs_n_i,
    input wire logic wr_n_i,
    output logic [11:0] code_o
);
    // Level-sensitive latch: it follows all twelve pins while both strobes are low.
    // A clocked copy would hide glitches in the strobes, so a true latch is kept here.
    always_latch begin
        if (!cs_n_i && !wr_n_i) begin
            code_o = data_i;
        end
        // Otherwise the last code is held and the data pins are ignored.
    end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the converter write-port controller.
// Assumes the latch model sits on the pins; drives everything from the 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "dacw_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module testbench;
    logic clock_i = 1'b0; // System clock.
    logic rst_i = 1'b1; // Synchronous reset.
    logic req_i = 1'b0; // Write request.
    logic [11:0] code_i = 12'h000; // Code to write.
    logic split_i = 1'b0; // Two-access mode.
    logic stream_i = 1'b0; // Transparent mode.
    logic [11:0] dac_data_o; // Data pins.
    logic dac_cs_n_o; // Select pin, active low.
    logic dac_wr_n_o; // Write pin, active low.
    logic busy_o; // Busy flag.
    logic done_o; // Done pulse.
    logic [11:0] latch_code; // Code held by the modelled latch.
    logic [11:0] prev_code = 12'h000; // Last completed code, for split high bits.
    int error_cnt = 0; // Mismatches seen.
    int num_checks = 0; // Comparisons made.
    int cycle_cnt = 0; // Cycles since time zero.

    // The clock toggles every half period of 20 ns.
    always #10 clock_i = ~clock_i;

    dacw_ctrl uut (.clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .code_i(code_i), .split_i(split_i),
        .stream_i(stream_i), .dac_data_o(dac_data_o), .dac_cs_n_o(dac_cs_n_o), .dac_wr_n_o(dac_wr_n_o),
        .busy_o(busy_o), .done_o(done_o));
    dacw_dac_model dac (.data_i(dac_data_o), .cs_n_i(dac_cs_n_o), .wr_n_i(dac_wr_n_o), .code_o(latch_code));

    ////////////////////////////////////////////////////////////////////////////
    // Compares one value; four-state equality so an unknown never matches.
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic finish_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The whole run needs well under 400 cycles; the ceiling leaves margin for a hang.
    always @(posedge clock_i) begin
        cycle_cnt++;
        if (cycle_cnt == 2000) begin
            error_cnt++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One write, walked cycle by cycle; poke raises a refused request in mid-write.
    task automatic do_write(input logic [11:0] c, input logic sp, input logic poke);
        logic [11:0] lo;
        int last;
        lo = {prev_code[11:8], c[7:0]};
        last = sp ? 31 : 16;
        @(posedge clock_i);
        req_i <= 1'b1;
        code_i <= c;
        split_i <= sp;
        for (int k = 1; k <= last; k++) begin
            @(posedge clock_i);
            req_i <= poke && (k == 5);
            code_i <= (poke && k == 5) ? ~c : c;
            @(negedge clock_i);
            check(dac_cs_n_o, k == last);
            check(dac_wr_n_o, !((k >= 10 && k <= 14) || (k >= 25 && k <= 29)));
            check(dac_data_o, (sp && k < 16) ? lo : c);
            check(done_o, k == last);
            check(busy_o, k != last);
            if (k == 15) begin
                check(latch_code, sp ? lo : c);
            end
        end
        check(latch_code, c);
        prev_code = c;
        // The poked request must not start a second write; the latch holds.
        @(negedge clock_i);
        check(dac_cs_n_o, 1'b1);
        check(latch_code, c);
        $display("write %h split=%0d done", c, sp);
    endtask

    // Transparent mode: pins and latch follow the code one cycle late.
    // A request raised together with streaming must lose, so the write strobe is low at once.
    task automatic do_stream(input logic [11:0] a, input logic [11:0] b);
        @(posedge clock_i);
        stream_i <= 1'b1;
        req_i <= 1'b1;
        code_i <= a;
        @(posedge clock_i);
        req_i <= 1'b0;
        code_i <= b;
        @(negedge clock_i);
        check(dac_cs_n_o, 1'b0);
        check(dac_wr_n_o, 1'b0);
        check(busy_o, 1'b1);
        check(dac_data_o, a);
        check(latch_code, a);
        @(posedge clock_i);
        stream_i <= 1'b0;
        @(negedge clock_i);
        check(latch_code, b);
        @(posedge clock_i);
        code_i <= ~b;
        @(negedge clock_i);
        check(dac_cs_n_o, 1'b1);
        check(busy_o, 1'b0);
        check(done_o, 1'b0);
        @(negedge clock_i);
        check(latch_code, b);
        check(dac_data_o, b);
        prev_code = b;
        $display("stream done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, single and split writes, streaming, split after streaming.
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        check(dac_data_o, `DACW_CODE_RESET);
        check(dac_cs_n_o, 1'b1);
        check(dac_wr_n_o, 1'b1);
        check(busy_o, 1'b0);
        check(done_o, 1'b0);
        $display("reset done");
        do_write(12'hA5C, 1'b0, 1'b0);
        do_write(12'h3C1, 1'b1, 1'b1);
        do_write(12'h801, 1'b0, 1'b1);
        do_stream(12'h5A3, 12'h7FE);
        do_write(12'hF0F, 1'b1, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
